// *** src/ssr_params.svh ***
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

// Event status bit positions
`define SSR_EV_OPC 0
`define SSR_EV_RQC 1
`define SSR_EV_QRY 2
`define SSR_EV_DEV 3
`define SSR_EV_EXE 4
`define SSR_EV_CMD 5
`define SSR_EV_USR 6
`define SSR_EV_PON 7

// Status byte bit positions
`define SSR_SB_OFS 1
`define SSR_SB_WID 2
`define SSR_SB_RAMP 3
`define SSR_SB_MAV 4
`define SSR_SB_ESB 5
`define SSR_SB_RQS 6

// Reset values and masks
`define SSR_BYTE_ZERO 8'h00
`define SSR_SRE_WMASK 8'hbf
`define SSR_STB_MASK 8'h3e
`define SSR_SETTING_ZERO 44'h000_0000_0000

// Front panel message time
`define SSR_DISP_TIME_MS 1000
`define SSR_CLK_PERIOD_NS 100
`define SSR_NS_PER_MS 1000000
`define SSR_DISP_CYCLES (`SSR_DISP_TIME_MS * `SSR_NS_PER_MS / `SSR_CLK_PERIOD_NS)

`endif

// *** src/ssr_pkg.sv ***
package ssr_pkg;

  // Front panel error message shown
  typedef enum logic [1:0] {
    SSR_DISP_NONE,
    SSR_DISP_BAD_HEADER,
    SSR_DISP_BAD_PARAMETER,
    SSR_DISP_INCOMPATIBLE_SETTING
  } ssr_disp_code_t;

  // Display timer state
  typedef enum logic {
    SSR_SHOW_IDLE,
    SSR_SHOW_ON
  } ssr_show_state_t;

endpackage

// *** src/ssr_core.sv ***
// How it works
// - Clear-status empties events and output queue
// - Device clear clears status, restores defaults
// - Eight-bit service request enable mask
// - Mask bit 6 ignored, reads zero
// - Writing zero clears every enable bit
// - Weights 2, 4 enable offset, width
// - Weights 16, 32 enable message, event
// - Event register cleared by status, power, read
// - Operation complete sets event bit 0
// - Request control event never set
// - Empty queue read sets event bit 2
// - Bad combination sets bit 3, parsing continues
// - Out of range data sets bit 4
// - Syntax fault or trigger sets bit 5
// - Push-button sets bit 6 always
// - Power restore sets bit 7
// - Event enable mask selects summary bit
// - Event enable weights map one-to-one
// - Setting query is side-effect free, cleared
// - Invalid command discarded, flagged, shown
// - Error codes shown about one second
// - Empty queue reads message-available false
// - Status bit 3 reports ramp error
// - Bit 6 summarises any service request
`timescale 1ns/1ps
`include "ssr_params.svh"

module ssr_core
  import ssr_pkg::*;
#(
  parameter int unsigned DISP_CYCLES = `SSR_DISP_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CLS_CMD,
  input wire logic DEV_CLEAR,
  input wire logic SRE_WR,
  input wire logic [7:0] SRE_DATA,
  input wire logic ESE_WR,
  input wire logic [7:0] ESE_DATA,
  input wire logic STB_RD,
  input wire logic SPOLL_RD,
  input wire logic SRE_RD,
  input wire logic ESE_RD,
  input wire logic ESR_RD,
  input wire logic SETTING_RD,
  input wire logic SETTING_WR,
  input wire logic [43:0] SETTING_DATA,
  input wire logic OPC_CMD,
  input wire logic OPS_DONE,
  input wire logic QUERY_EMPTY,
  input wire logic COMBINATION_FAULT,
  input wire logic RANGE_FAULT,
  input wire logic SYNTAX_FAULT,
  input wire logic GET_IN_MESSAGE,
  input wire logic MANUAL_BTN,
  input wire logic MSG_AVAIL,
  input wire logic OFFSET_ERR,
  input wire logic WIDTH_ERR,
  input wire logic RAMP_ERR,
  output logic [7:0] READ_DATA,
  output logic READ_VALID,
  output logic [43:0] SETTING_OUT,
  output logic SRQ,
  output logic QUEUE_FLUSH,
  output logic FACTORY_RESET,
  output logic DISCARD_UNIT,
  output logic [1:0] DISP_CODE
);

  logic [7:0] sre_q, sre_d;
  logic [7:0] ese_q, ese_d;
  logic [7:0] esr_q, esr_d;
  logic [43:0] setting_q, setting_d;
  logic opc_arm_q, opc_arm_d;
  logic pon_pend_q;
  logic rqs_q, rqs_d;
  logic reason_q;
  logic btn_s1_q, btn_s2_q, btn_s3_q;
  logic [7:0] read_data_q, read_data_d;
  logic read_valid_q;
  logic srq_q, flush_q, factory_q, discard_q;
  ssr_show_state_t show_q, show_d;
  ssr_disp_code_t code_q, code_d;
  logic [23:0] disp_cnt_q, disp_cnt_d;

  // Event sources and clear terms
  wire btn_press = btn_s2_q & ~btn_s3_q;
  wire clear_all = CLS_CMD | DEV_CLEAR;
  wire esr_clr = clear_all | ESR_RD;
  wire opc_hit = opc_arm_q & OPS_DONE;
  wire bad_header = SYNTAX_FAULT | GET_IN_MESSAGE;
  wire [7:0] esr_set;
  assign esr_set[`SSR_EV_OPC] = opc_hit;
  assign esr_set[`SSR_EV_RQC] = 1'b0;
  assign esr_set[`SSR_EV_QRY] = QUERY_EMPTY;
  assign esr_set[`SSR_EV_DEV] = COMBINATION_FAULT;
  assign esr_set[`SSR_EV_EXE] = RANGE_FAULT;
  assign esr_set[`SSR_EV_CMD] = bad_header;
  assign esr_set[`SSR_EV_USR] = btn_press;
  assign esr_set[`SSR_EV_PON] = pon_pend_q;

  // Set wins over every clear so no event slips through
  assign esr_d = (esr_q & ~{8{esr_clr}}) | esr_set;

  // Event summary is any enabled event
  wire esb = |(esr_q & ese_q);

  // Message available drops as soon as the queue is flushed
  wire mav = MSG_AVAIL & ~flush_q;

  // Status byte without bit 6
  wire [7:0] stb_raw;
  assign stb_raw[0] = 1'b0;
  assign stb_raw[`SSR_SB_OFS] = OFFSET_ERR;
  assign stb_raw[`SSR_SB_WID] = WIDTH_ERR;
  assign stb_raw[`SSR_SB_RAMP] = RAMP_ERR;
  assign stb_raw[`SSR_SB_MAV] = mav;
  assign stb_raw[`SSR_SB_ESB] = esb;
  assign stb_raw[`SSR_SB_RQS] = 1'b0;
  assign stb_raw[7] = 1'b0;

  // Master summary: any enabled status bit
  wire mss = |(stb_raw & sre_q & `SSR_STB_MASK);
  wire new_reason = mss & ~reason_q;

  // Serial poll hides the request until a new reason arrives
  assign rqs_d = ~DEV_CLEAR &
                 (new_reason | (rqs_q & mss & ~SPOLL_RD));

  // Mask writes; bit 6 of the request mask is dropped, zero clears all
  assign sre_d = SRE_WR ? (SRE_DATA & `SSR_SRE_WMASK) : sre_q;
  assign ese_d = ESE_WR ? ESE_DATA : ese_q;

  // Operation complete waits for pending work
  assign opc_arm_d = ~clear_all & (OPC_CMD | (opc_arm_q & ~OPS_DONE));

  // Setting word goes back to all zeros on device clear
  assign setting_d = DEV_CLEAR ? `SSR_SETTING_ZERO :
                     (SETTING_WR ? SETTING_DATA : setting_q);

  // Read mux; bit 6 differs between poll and query
  wire [7:0] stb_query = stb_raw | ({7'h00, mss} << `SSR_SB_RQS);
  wire [7:0] stb_poll = stb_raw | ({7'h00, rqs_q} << `SSR_SB_RQS);
  wire any_rd = STB_RD | SPOLL_RD | SRE_RD | ESE_RD | ESR_RD;
  assign read_data_d = STB_RD ? stb_query :
                       SPOLL_RD ? stb_poll :
                       SRE_RD ? sre_q :
                       ESE_RD ? ese_q :
                       ESR_RD ? esr_q : `SSR_BYTE_ZERO;

  // Display code: header beats parameter beats combination
  wire any_fault = bad_header | RANGE_FAULT | COMBINATION_FAULT;
  wire ssr_disp_code_t fault_code = bad_header ? SSR_DISP_BAD_HEADER :
    RANGE_FAULT ? SSR_DISP_BAD_PARAMETER : SSR_DISP_INCOMPATIBLE_SETTING;
  wire disp_done = (disp_cnt_q == 24'(DISP_CYCLES - 1));

  // Display timer; a fresh fault restarts the full second
  always_comb begin
    show_d = show_q;
    code_d = code_q;
    disp_cnt_d = disp_cnt_q;
    unique case (show_q)
      SSR_SHOW_IDLE: begin
        if (any_fault) begin
          show_d = SSR_SHOW_ON;
          code_d = fault_code;
          disp_cnt_d = 24'h000000;
        end
      end
      SSR_SHOW_ON: begin
        if (any_fault) begin
          code_d = fault_code;
          disp_cnt_d = 24'h000000;
        end else if (disp_done) begin
          show_d = SSR_SHOW_IDLE;
          code_d = SSR_DISP_NONE;
        end else begin
          disp_cnt_d = disp_cnt_q + 24'h000001;
        end
      end
    endcase
  end

  // Button synchroniser; first stage read only by second
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_s3_q <= 1'b0;
    end else begin
      btn_s1_q <= MANUAL_BTN;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
    end
  end

  // Status registers; power-on pending fires once after release
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      esr_q <= `SSR_BYTE_ZERO;
      sre_q <= `SSR_BYTE_ZERO;
      ese_q <= `SSR_BYTE_ZERO;
      opc_arm_q <= 1'b0;
      pon_pend_q <= 1'b1;
      rqs_q <= 1'b0;
      reason_q <= 1'b0;
      setting_q <= `SSR_SETTING_ZERO;
    end else begin
      esr_q <= esr_d;
      sre_q <= sre_d;
      ese_q <= ese_d;
      opc_arm_q <= opc_arm_d;
      pon_pend_q <= 1'b0;
      rqs_q <= rqs_d;
      reason_q <= mss;
      setting_q <= setting_d;
    end
  end

  // Output flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      read_data_q <= `SSR_BYTE_ZERO;
      read_valid_q <= 1'b0;
      srq_q <= 1'b0;
      flush_q <= 1'b0;
      factory_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      read_data_q <= read_data_d;
      read_valid_q <= any_rd;
      srq_q <= rqs_d;
      flush_q <= clear_all;
      factory_q <= DEV_CLEAR;
      discard_q <= bad_header | RANGE_FAULT;
    end
  end

  // Display flops; timer is long, so simulations shrink it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      show_q <= SSR_SHOW_IDLE;
      code_q <= SSR_DISP_NONE;
      disp_cnt_q <= 24'h000000;
    end else begin
      show_q <= show_d;
      code_q <= code_d;
      disp_cnt_q <= disp_cnt_d;
    end
  end

  assign READ_DATA = read_data_q;
  assign READ_VALID = read_valid_q;
  assign SETTING_OUT = setting_q;
  assign SRQ = srq_q;
  assign QUEUE_FLUSH = flush_q;
  assign FACTORY_RESET = factory_q;
  assign DISCARD_UNIT = discard_q;
  assign DISP_CODE = code_q;

  // Checks
  sequence s_clear_status;
    CLS_CMD && !ESR_RD && (esr_set == `SSR_BYTE_ZERO);
  endsequence

  sequence s_flushed;
    QUEUE_FLUSH && (esr_q == `SSR_BYTE_ZERO) && !stb_raw[`SSR_SB_MAV];
  endsequence

  property p_cls_clears;
    @(posedge CLK) disable iff (!RST_N)
    s_clear_status |=> s_flushed;
  endproperty
  a_cls_clears: assert property (p_cls_clears)
    else $error("clear status left events or queue");

  property p_dcl_factory;
    @(posedge CLK) disable iff (!RST_N)
    DEV_CLEAR |=> FACTORY_RESET && QUEUE_FLUSH && !SRQ
      && (SETTING_OUT == `SSR_SETTING_ZERO);
  endproperty
  a_dcl_factory: assert property (p_dcl_factory)
    else $error("device clear did not reset setup");

  property p_sre_bit6;
    @(posedge CLK) disable iff (!RST_N)
    SRE_RD && !STB_RD && !SPOLL_RD |=> !READ_DATA[`SSR_SB_RQS];
  endproperty
  a_sre_bit6: assert property (p_sre_bit6)
    else $error("mask bit 6 read back set");

  property p_sre_zero;
    @(posedge CLK) disable iff (!RST_N)
    SRE_WR && (SRE_DATA == `SSR_BYTE_ZERO) |=> (sre_q == `SSR_BYTE_ZERO);
  endproperty
  a_sre_zero: assert property (p_sre_zero)
    else $error("mask write of zero left bits set");

  property p_esr_destructive;
    @(posedge CLK) disable iff (!RST_N)
    ESR_RD && (esr_set == `SSR_BYTE_ZERO)
      |=> esr_q == `SSR_BYTE_ZERO;
  endproperty
  a_esr_destructive: assert property (p_esr_destructive)
    else $error("event register survived its read");

  property p_opc_sets;
    @(posedge CLK) disable iff (!RST_N)
    opc_arm_q && OPS_DONE && !clear_all |=> esr_q[`SSR_EV_OPC];
  endproperty
  a_opc_sets: assert property (p_opc_sets)
    else $error("operation complete not recorded");

  property p_rqc_never;
    @(posedge CLK) disable iff (!RST_N)
    !esr_q[`SSR_EV_RQC];
  endproperty
  a_rqc_never: assert property (p_rqc_never)
    else $error("request control event set");

  property p_error_events;
    @(posedge CLK) disable iff (!RST_N)
    (QUERY_EMPTY || RANGE_FAULT || SYNTAX_FAULT) |=>
      esr_q[`SSR_EV_QRY] || esr_q[`SSR_EV_EXE] || esr_q[`SSR_EV_CMD];
  endproperty
  a_error_events: assert property (p_error_events)
    else $error("error event not recorded");

  property p_button;
    @(posedge CLK) disable iff (!RST_N)
    $rose(btn_s2_q) |=> esr_q[`SSR_EV_USR];
  endproperty
  a_button: assert property (p_button)
    else $error("push-button event lost");

  property p_srq_follows;
    @(posedge CLK) disable iff (!RST_N)
    $rose(mss) && !DEV_CLEAR |=> SRQ;
  endproperty
  a_srq_follows: assert property (p_srq_follows)
    else $error("service request not raised");

  property p_discard;
    @(posedge CLK) disable iff (!RST_N)
    SYNTAX_FAULT |=> DISCARD_UNIT
      && DISP_CODE == SSR_DISP_BAD_HEADER;
  endproperty
  a_discard: assert property (p_discard)
    else $error("invalid command not discarded and shown");

  property p_combo_keeps_parsing;
    @(posedge CLK) disable iff (!RST_N)
    COMBINATION_FAULT && !SYNTAX_FAULT && !RANGE_FAULT && !GET_IN_MESSAGE
      |=> !DISCARD_UNIT;
  endproperty
  a_combo_keeps_parsing: assert property (p_combo_keeps_parsing)
    else $error("combination fault stopped parsing");

  property p_setting_read;
    @(posedge CLK) disable iff (!RST_N)
    SETTING_RD && !SETTING_WR && !DEV_CLEAR |=> $stable(SETTING_OUT);
  endproperty
  a_setting_read: assert property (p_setting_read)
    else $error("setting query altered the word");

endmodule // ssr_core

// *** test/ssr_host_model.sv ***
`timescale 1ns/1ps
// Bus controller side: one common command per call
module ssr_host_model (
  input wire logic clk,
  output logic [16:0] strobe,
  output logic [43:0] word_out
);
  // Idle until the first command
  initial begin
    strobe = 17'h00000;
    word_out = 44'h0;
  end

  // Raised after an edge, held one whole cycle, then dropped
  task automatic send(input logic [16:0] s, input logic [43:0] d);
    @(posedge clk);
    #1;
    strobe = s;
    word_out = d;
    @(posedge clk);
    #1;
    strobe = 17'h00000;
  endtask
endmodule // ssr_host_model

// *** test/test_status_service_request.sv ***
`timescale 1ns/1ps
module test_status_service_request;
  localparam int DISP = 20;
  localparam int CLS = 0, DCL = 1, SREW = 2, ESEW = 3, STBR = 4, SPR = 5;
  localparam int SRER = 6, ESER = 7, ESRR = 8, SETR = 9, SETW = 10;
  localparam int OPC = 11, QE = 12, SF = 15;
  logic clk = 1'b0;
  logic rst_n;
  logic [5:0] lv;
  logic [16:0] s;
  logic [43:0] w;
  logic [7:0] read_data;
  logic read_valid, srq, queue_flush, factory_reset, discard_unit;
  logic [43:0] setting_out;
  logic [1:0] disp_code;
  logic [1:0] dc [5] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h1};
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'h90f5ea0a;
  logic [31:0] r;
  logic [43:0] v;
  int miscompares = 0;
  int n_tests = 0;

  ssr_core #(.DISP_CYCLES(DISP)) dut (
    .CLK(clk), .RST_N(rst_n), .CLS_CMD(s[0]), .DEV_CLEAR(s[1]),
    .SRE_WR(s[2]), .SRE_DATA(w[7:0]), .ESE_WR(s[3]), .ESE_DATA(w[7:0]),
    .STB_RD(s[4]), .SPOLL_RD(s[5]), .SRE_RD(s[6]), .ESE_RD(s[7]),
    .ESR_RD(s[8]), .SETTING_RD(s[9]), .SETTING_WR(s[10]),
    .SETTING_DATA(w), .OPC_CMD(s[11]), .OPS_DONE(lv[4]),
    .QUERY_EMPTY(s[12]), .COMBINATION_FAULT(s[13]), .RANGE_FAULT(s[14]),
    .SYNTAX_FAULT(s[15]), .GET_IN_MESSAGE(s[16]), .MANUAL_BTN(lv[5]),
    .MSG_AVAIL(lv[3]), .OFFSET_ERR(lv[0]), .WIDTH_ERR(lv[1]),
    .RAMP_ERR(lv[2]), .READ_DATA(read_data), .READ_VALID(read_valid),
    .SETTING_OUT(setting_out), .SRQ(srq), .QUEUE_FLUSH(queue_flush),
    .FACTORY_RESET(factory_reset), .DISCARD_UNIT(discard_unit),
    .DISP_CODE(disp_code)
  );
  ssr_host_model host (.clk(clk), .strobe(s), .word_out(w));

  // 10 MHz clock
  always #50 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string n, logic [43:0] e, logic [43:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmd(int i, logic [43:0] d);
    host.send(17'h00001 << i, d);
  endtask

  // Note the answer first, the monitor pairs it later
  task automatic rd(int i, logic [7:0] e);
    exp_q.push_back(e);
    cmd(i, 44'h0);
  endtask

  // Waits land off the edge so level changes never race it
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Pair each read answer with the oldest expectation, mid-cycle
  always @(negedge clk) begin
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("READ_VALID", 44'h0, 44'h1);
      else
        chk("READ_DATA", 44'(exp_q.pop_front()), 44'(read_data));
    end
  end

  // Whole run is under a thousand cycles; this cuts a hang
  initial begin
    #3000000;
    miscompares++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    lv = 6'h00;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(ESRR, 8'h80);
    rd(ESRR, 8'h00);
    cmd(SREW, 44'hff);
    rd(SRER, 8'hbf);
    r = rnd();
    cmd(SREW, 44'(r[7:0]));
    rd(SRER, r[7:0] & 8'hbf);
    cmd(SREW, 44'h0);
    rd(SRER, 8'h00);
    r = rnd();
    cmd(ESEW, 44'(r[7:0]));
    rd(ESER, r[7:0]);
    // Each source sets its bit, syntax and trigger both bit 5; faults also show on the panel
    for (int i = 0; i < 5; i++) begin
      cmd(QE + i, 44'h0);
      if (i > 0) begin
        chk("DISP_CODE", 44'(dc[i]), 44'(disp_code));
        chk("DISCARD_UNIT", 44'(i > 1), 44'(discard_unit));
      end
      wt(DISP + 4);
      chk("DISP_CODE idle", 44'h0, 44'(disp_code));
      rd(ESRR, 8'h04 << ((i == 4) ? 3 : i));
    end
    lv[4] = 1'b1;
    cmd(OPC, 44'h0);
    wt(3);
    rd(ESRR, 8'h01);
    lv[5] = 1'b1;
    wt(4);
    lv[5] = 1'b0;
    rd(ESRR, 8'h40);
    // Weights 2, 4, 8, 16 each raise the request, then a poll drops it
    for (int i = 0; i < 4; i++) begin
      cmd(SREW, 44'h2 << i);
      lv[i] = 1'b1;
      wt(3);
      chk("SRQ", 44'h1, 44'(srq));
      rd(STBR, (8'h02 << i) | 8'h40);
      rd(SPR, (8'h02 << i) | 8'h40);
      wt(1);
      chk("SRQ polled", 44'h0, 44'(srq));
      lv[i] = 1'b0;
    end
    cmd(SREW, 44'h3c);
    lv[0] = 1'b1;
    wt(3);
    chk("SRQ masked", 44'h0, 44'(srq));
    lv[0] = 1'b0;
    // Enabled command error reaches the line through the summary bit
    cmd(ESEW, 44'h20);
    cmd(SREW, 44'h20);
    cmd(SF, 44'h0);
    wt(3);
    chk("SRQ summary", 44'h1, 44'(srq));
    lv[3] = 1'b1;
    cmd(CLS, 44'h0);
    chk("QUEUE_FLUSH", 44'h1, 44'(queue_flush));
    // Queue model empties one cycle after the flush pulse
    wt(1);
    lv[3] = 1'b0;
    rd(STBR, 8'h00);
    rd(ESRR, 8'h00);
    // Setting word of eleven decimal digits
    for (int k = 0; k < 11; k++)
      v[4*k +: 4] = 4'(rnd() % 10);
    cmd(SETW, v);
    chk("SETTING_OUT", v, setting_out);
    cmd(SETR, 44'h0);
    chk("SETTING_OUT kept", v, setting_out);
    // Device clear while a request stands
    cmd(SREW, 44'h2);
    lv[0] = 1'b1;
    wt(3);
    cmd(DCL, 44'h0);
    chk("FACTORY_RESET", 44'h1, 44'(factory_reset));
    chk("SETTING_OUT zero", 44'h0, setting_out);
    chk("SRQ cleared", 44'h0, 44'(srq));
    lv[0] = 1'b0;
    rd(ESRR, 8'h00);
    wt(3);
    chk("pending reads", 44'h0, 44'(exp_q.size()));
    wrap_up();
  end
endmodule // test_status_service_request
